// file: fifo_buf.sv
// Write-data FIFO with valid/ready on both sides
`timescale 1ns/10ps
module fifo_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr_r;
  logic [AW:0] rptr_r;
  logic [AW:0] wptr_nxt;
  logic [AW:0] rptr_nxt;
  logic ready_nxt;
  logic push;
  logic pop;

  assign out_valid_o = (wptr_r != rptr_r);
  assign out_data_o = mem[rptr_r[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    wptr_nxt = wptr_r + (AW+1)'(push);
    rptr_nxt = rptr_r + (AW+1)'(pop);
    ready_nxt = ((wptr_nxt - rptr_nxt) != (AW+1)'(DEPTH));
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      in_ready_o <= 1'b0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      in_ready_o <= ready_nxt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wptr_r[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// file: nand_dev_model.sv
// Behavioural flash device for the host controller bench
`timescale 1ns/10ps
module nand_dev_model import nand_host_pkg::*; (
  input wire pins_t pins_i,
  output logic [7:0] io_o = 8'h5a,
  output logic rb_n_o = 1'b1
);
  logic [7:0] cnt = 8'h00;
  task automatic busy(int n, bit wr);
    #50 rb_n_o = 1'b0;
    repeat (n) if (!wr || pins_i.wp_n) #10;
    rb_n_o = 1'b1;
  endtask
  always @(posedge pins_i.we_n) if (!pins_i.ce_n && pins_i.cle && !pins_i.ale) begin
    cnt = 8'h00;
    case (pins_i.io)
      8'h30, 8'h31, 8'h3f: busy(250, 0);
      8'h10, 8'h15, 8'hd0: busy(900, 1);
      8'hd1: busy(80, 1);
      8'hff: busy(200, 0);
      default: ;
    endcase
  end
  always @(negedge pins_i.read_strobe_n) if (!pins_i.ce_n && pins_i.we_n) io_o = cnt;
  always @(posedge pins_i.read_strobe_n) begin
    cnt++;
    #20 io_o = ~io_o;
  end
endmodule

// file: nand_host_chk.sv
// Bus and handshake checker for the NAND host controller
`timescale 1ns/10ps
module nand_host_chk import nand_host_pkg::*; (
  input wire logic core_clk_i, rst_n_i, req_valid_i, req_ready_o, rd_valid_o, rb_n_i,
  input wire resp_t resp_o,
  input wire pins_t pins_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_cmd; pins_o.cle |-> !pins_o.ale && pins_o.read_strobe_n; endproperty
  a_cmd: assert property (p_cmd) else $error("bad command cycle");
  property p_adr; pins_o.ale |-> !pins_o.cle && pins_o.read_strobe_n; endproperty
  a_adr: assert property (p_adr) else $error("bad address cycle");
  property p_dout;
    !pins_o.read_strobe_n |-> pins_o.we_n && !pins_o.cle && !pins_o.ale && !pins_o.io_oe;
  endproperty
  a_dout: assert property (p_dout) else $error("bad data out cycle");
  property p_we; $fell(pins_o.we_n) |=> !pins_o.we_n ##1 pins_o.we_n; endproperty
  a_we: assert property (p_we) else $error("bad write strobe");
  property p_done; resp_o.done |=> !resp_o.done; endproperty
  a_done: assert property (p_done) else $error("done too long");
  property p_take; req_valid_i && req_ready_o |=> !req_ready_o; endproperty
  a_take: assert property (p_take) else $error("ready after take");
  property p_rdy; resp_o.done |-> ##[1:2] req_ready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after done");
  property p_busy; !rb_n_i [*4] |-> pins_o.we_n && pins_o.read_strobe_n; endproperty
  a_busy: assert property (p_busy) else $error("strobe while busy");
  c_ref: cover property (resp_o.refused);
  c_rd: cover property (rd_valid_o);
  c_busy: cover property (!rb_n_i ##1 rb_n_i);
endmodule
bind nand_host_ctrl nand_host_chk chk_u (.*);

// file: nand_host_ctrl.sv
// Host controller driving an asynchronous NAND flash bus
// Functional notes
// - Command byte: chip select low, read strobe high, CLE high, ALE low; WP high on writes.
// - Address byte: chip select low, read strobe high, CLE low, ALE high; WP high on writes.
// - Both latches low: write strobe moves input data, read strobe returns output data.
// - A page takes at most 4 partial programs between erases; only the last programmed page is counted, and any erase clears the count.
// - With randomizer on, a covered page area is programmed once between erases; checked only against the last programmed page.
// - Wake: wait 1 us after entry, pulse chip select 20 ns, ready within 35 us.
`timescale 1ns/10ps
module nand_host_ctrl import nand_host_pkg::*; #(
  parameter int PROG_CYC = PAGE_PROGRAM_CYC,
  parameter int PROG_SCR_CYC = PAGE_PROGRAM_SCRAMBLED_CYC,
  parameter int CACHE_PROG_CYC = CACHE_PROGRAM_BUSY_CYC,
  parameter int CACHE_PROG_SCR_CYC = CACHE_PROGRAM_BUSY_SCRAMBLED_CYC,
  parameter int ERASE_CYC = BLOCK_ERASE_CYC,
  parameter int ERASE_DUAL_CYC = DUAL_ERASE_CYC,
  parameter int RST_CYC = RESET_CYC,
  parameter int FIFO_DEPTH = 16
)(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire req_t req_i,
  output logic req_ready_o,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  input wire logic abort_i,
  output resp_t resp_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output pins_t pins_o,
  input wire logic [7:0] io_i,
  input wire logic rb_n_i
);
  typedef enum logic [3:0] {
    S_IDLE, S_WP, S_CMD1, S_ADDR, S_ADL, S_DIN, S_CMD2, S_WB, S_BUSY, S_RR, S_WHR,
    S_DOUT, S_WAKE, S_HOLD, S_DONE
  } state_t;

  logic rst_q1_r;
  logic rst_n_sync;
  logic rb_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_pop;

  state_t state_r;
  state_t state_nxt;
  state_t post_state;
  logic [2:0] ph_r;
  logic [2:0] ph_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic [12:0] cnt_r;
  logic [12:0] cnt_nxt;
  logic [2:0] abyte_r;
  logic [2:0] abyte_nxt;
  logic [39:0] addr_r;
  logic [39:0] addr_nxt;
  req_t cur_r;
  req_t cur_nxt;
  op_info_t info_r;
  op_info_t info_nxt;
  logic second_r;
  logic second_nxt;
  logic to_r;
  logic to_nxt;
  pins_t pins_nxt;
  resp_t resp_nxt;
  logic [7:0] rd_data_nxt;
  logic rd_valid_nxt;
  logic ready_nxt;
  logic [23:0] npp_row_r;
  logic [23:0] npp_row_nxt;
  logic [2:0] npp_cnt_r;
  logic [2:0] npp_cnt_nxt;
  logic wr_strobe_end;
  logic is_prog;
  logic [2:0] npp_limit;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1_r <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n_sync <= rst_q1_r;
    end
  end

  sync3 #(.RST_VAL(1'b1)) u_rb_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_sync),
    .in_i(rb_n_i),
    .out_o(rb_ready)
  );

  fifo_buf #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_sync),
    .in_valid_i(wr_valid_i),
    .in_data_i(wr_data_i),
    .in_ready_o(wr_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  // Per-operation sequence and busy limit
  function automatic op_info_t op_decode(input op_t op, input logic scr);
    op_info_t d;
    d = '0;
    case (op)
      OP_READ: begin
        d = '{CMD_READ_SETUP, CMD_READ_CONFIRM, 1'b1, 1'b1, 3'd0, 3'd4, DIR_OUT, 1'b1, 1'b0,
          TMR_W'(ARRAY_TO_BUFFER_CYC)};
      end
      OP_CACHE_READ_SEQ: begin
        d = '{CMD_CACHE_READ_SEQ, 8'h00, 1'b0, 1'b0, 3'd0, 3'd0, DIR_OUT, 1'b1, 1'b0,
          TMR_W'(CACHE_READ_BUSY_CYC)};
      end
      OP_CACHE_READ_END: begin
        d = '{CMD_CACHE_READ_END, 8'h00, 1'b0, 1'b0, 3'd0, 3'd0, DIR_OUT, 1'b1, 1'b0,
          TMR_W'(CACHE_READ_BUSY_CYC)};
      end
      OP_PROGRAM: begin
        d = '{CMD_PROGRAM_SETUP, CMD_PROGRAM_CONFIRM, 1'b1, 1'b1, 3'd0, 3'd4, DIR_IN, 1'b1,
          1'b1, scr ? TMR_W'(PROG_SCR_CYC) : TMR_W'(PROG_CYC)};
      end
      OP_CACHE_PROGRAM: begin
        d = '{CMD_PROGRAM_SETUP, CMD_CACHE_PROGRAM, 1'b1, 1'b1, 3'd0, 3'd4, DIR_IN, 1'b1,
          1'b1, scr ? TMR_W'(CACHE_PROG_SCR_CYC) : TMR_W'(CACHE_PROG_CYC)};
      end
      OP_ERASE: begin
        d = '{CMD_ERASE_SETUP, CMD_ERASE_CONFIRM, 1'b1, 1'b1, 3'd2, 3'd4, DIR_NONE, 1'b1,
          1'b1, TMR_W'(ERASE_CYC)};
      end
      OP_ERASE_DUAL: begin
        d = '{CMD_ERASE_SETUP, CMD_PLANE_NEXT, 1'b1, 1'b1, 3'd2, 3'd4, DIR_NONE, 1'b1,
          1'b1, TMR_W'(DUAL_PLANE_BUSY_CYC)};
      end
      OP_SET_FEATURE: begin
        d = '{CMD_SET_FEATURE, 8'h00, 1'b0, 1'b1, 3'd0, 3'd0, DIR_IN, 1'b1, 1'b0,
          TMR_W'(FEATURE_ACCESS_BUSY_CYC)};
      end
      OP_GET_FEATURE: begin
        d = '{CMD_GET_FEATURE, 8'h00, 1'b0, 1'b1, 3'd0, 3'd0, DIR_OUT, 1'b1, 1'b0,
          TMR_W'(FEATURE_ACCESS_BUSY_CYC)};
      end
      OP_STATUS: begin
        d = '{CMD_STATUS, 8'h00, 1'b0, 1'b0, 3'd0, 3'd0, DIR_OUT, 1'b0, 1'b0, '0};
      end
      OP_RESET: begin
        d = '{CMD_RESET, 8'h00, 1'b0, 1'b0, 3'd0, 3'd0, DIR_NONE, 1'b1, 1'b0,
          TMR_W'(RST_CYC)};
      end
      OP_POWERDOWN: begin
        d = '{CMD_POWERDOWN, 8'h00, 1'b0, 1'b0, 3'd0, 3'd0, DIR_NONE, 1'b0, 1'b0,
          TMR_W'(POWERDOWN_ENTRY_CYC)};
      end
      OP_WAKE: begin
        d = '{8'h00, 8'h00, 1'b0, 1'b0, 3'd0, 3'd0, DIR_NONE, 1'b0, 1'b0,
          TMR_W'(POWERDOWN_EXIT_CYC)};
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction

  assign wr_strobe_end = (ph_r == 3'(WR_TOTAL_CYC - 1));
  assign is_prog = (req_i.op == OP_PROGRAM) || (req_i.op == OP_CACHE_PROGRAM);
  assign npp_limit = req_i.scrambled ? 3'(PARTIAL_PROGRAM_LIMIT_SCRAMBLED) :
    3'(PARTIAL_PROGRAM_LIMIT);

  always_comb begin
    if (info_r.busy) begin
      post_state = S_WB;
    end else if (cur_r.op == OP_POWERDOWN) begin
      post_state = S_HOLD;
    end else if (info_r.dir == DIR_OUT) begin
      post_state = S_WHR;
    end else begin
      post_state = S_DONE;
    end
  end

  always_comb begin
    state_nxt = state_r;
    ph_nxt = ph_r;
    tmr_nxt = tmr_r;
    cnt_nxt = cnt_r;
    abyte_nxt = abyte_r;
    addr_nxt = addr_r;
    cur_nxt = cur_r;
    info_nxt = info_r;
    second_nxt = second_r;
    to_nxt = to_r;
    pins_nxt = pins_o;
    pins_nxt.cle = 1'b0;
    pins_nxt.ale = 1'b0;
    pins_nxt.we_n = 1'b1;
    pins_nxt.read_strobe_n = 1'b1;
    pins_nxt.io_oe = 1'b0;
    resp_nxt = '0;
    rd_data_nxt = rd_data_o;
    rd_valid_nxt = 1'b0;
    ready_nxt = 1'b0;
    npp_row_nxt = npp_row_r;
    npp_cnt_nxt = npp_cnt_r;
    fifo_pop = 1'b0;
    case (state_r)
      S_IDLE: begin
        pins_nxt.ce_n = 1'b1;
        pins_nxt.wp_n = 1'b0;
        ready_nxt = rb_ready;
        if (req_valid_i && req_ready_o) begin
          ready_nxt = 1'b0;
          cur_nxt = req_i;
          info_nxt = op_decode(req_i.op, req_i.scrambled);
          addr_nxt = req_i.addr;
          second_nxt = 1'b0;
          to_nxt = 1'b0;
          tmr_nxt = '0;
          cnt_nxt = '0;
          ph_nxt = '0;
          if (is_prog && npp_row_r == req_i.addr[39:16] && npp_cnt_r >= npp_limit) begin
            resp_nxt.done = 1'b1;
            resp_nxt.refused = 1'b1;
          end else begin
            if (is_prog) begin
              npp_row_nxt = req_i.addr[39:16];
              npp_cnt_nxt = (npp_row_r == req_i.addr[39:16]) ? npp_cnt_r + 3'd1 : 3'd1;
            end else if (req_i.op == OP_ERASE || req_i.op == OP_ERASE_DUAL) begin
              npp_cnt_nxt = '0;
            end
            if (info_nxt.write_op) begin
              pins_nxt.wp_n = 1'b1;
              state_nxt = S_WP;
            end else if (req_i.op == OP_WAKE) begin
              state_nxt = S_WAKE;
            end else begin
              state_nxt = S_CMD1;
            end
          end
        end
      end
      S_WP: begin
        tmr_nxt = tmr_r + 1'b1;
        if (tmr_r == TMR_W'(WP_TO_WE_CYC - 1)) begin
          tmr_nxt = '0;
          state_nxt = S_CMD1;
        end
      end
      S_CMD1, S_CMD2, S_ADDR: begin
        pins_nxt.ce_n = 1'b0;
        pins_nxt.io_oe = 1'b1;
        pins_nxt.we_n = (ph_r >= 3'(WR_LOW_CYC));
        pins_nxt.cle = (state_r != S_ADDR);
        pins_nxt.ale = (state_r == S_ADDR);
        if (state_r == S_CMD1) begin
          pins_nxt.io = info_r.cmd1;
        end else if (state_r == S_CMD2) begin
          pins_nxt.io = second_r ? CMD_ERASE_CONFIRM : info_r.cmd2;
        end else begin
          pins_nxt.io = addr_r[{abyte_r, 3'b000} +: 8];
        end
        ph_nxt = ph_r + 3'd1;
        if (wr_strobe_end) begin
          ph_nxt = '0;
          tmr_nxt = '0;
          if (state_r == S_CMD1 && info_r.has_addr) begin
            abyte_nxt = info_r.first_addr;
            state_nxt = S_ADDR;
          end else if (state_r == S_ADDR && abyte_r != info_r.last_addr) begin
            abyte_nxt = abyte_r + 3'd1;
          end else if (state_r != S_CMD2 && info_r.dir == DIR_IN) begin
            state_nxt = S_ADL;
          end else if (state_r != S_CMD2 && info_r.has_cmd2) begin
            state_nxt = S_CMD2;
          end else begin
            state_nxt = post_state;
          end
        end
      end
      S_ADL: begin
        tmr_nxt = tmr_r + 1'b1;
        if (tmr_r == TMR_W'(ADDR_TO_DATA_CYC - 1)) begin
          state_nxt = S_DIN;
        end
      end
      S_DIN: begin
        pins_nxt.ce_n = 1'b0;
        pins_nxt.io_oe = 1'b1;
        pins_nxt.io = fifo_data;
        if (ph_r != 3'd0 || fifo_valid) begin
          pins_nxt.we_n = (ph_r >= 3'(WR_LOW_CYC));
          ph_nxt = ph_r + 3'd1;
          if (wr_strobe_end) begin
            ph_nxt = '0;
            fifo_pop = 1'b1;
            cnt_nxt = cnt_r + 13'd1;
            if (cnt_r == cur_r.len - 13'd1) begin
              state_nxt = info_r.has_cmd2 ? S_CMD2 : post_state;
            end
          end
        end
      end
      S_WB: begin
        pins_nxt.ce_n = 1'b1;
        tmr_nxt = tmr_r + 1'b1;
        if (tmr_r == TMR_W'(WE_TO_BUSY_CYC - 1)) begin
          tmr_nxt = '0;
          state_nxt = S_BUSY;
        end
      end
      S_BUSY: begin
        tmr_nxt = tmr_r + 1'b1;
        if (abort_i && info_r.write_op) begin
          pins_nxt.wp_n = 1'b0;
        end
        if (rb_ready || tmr_r == info_r.limit) begin
          to_nxt = to_r | !rb_ready;
          tmr_nxt = '0;
          if (cur_r.op == OP_ERASE_DUAL && !second_r) begin
            second_nxt = 1'b1;
            addr_nxt[39:16] = cur_r.addr2;
            info_nxt.limit = TMR_W'(ERASE_DUAL_CYC);
            state_nxt = S_CMD1;
          end else if (info_r.dir == DIR_OUT) begin
            state_nxt = S_RR;
          end else begin
            state_nxt = S_DONE;
          end
        end
      end
      S_RR, S_WHR: begin
        pins_nxt.ce_n = 1'b0;
        tmr_nxt = tmr_r + 1'b1;
        if ((state_r == S_RR && tmr_r == TMR_W'(READY_TO_RE_CYC - 1)) ||
            (state_r == S_WHR && tmr_r == TMR_W'(WE_TO_RE_CYC - 1))) begin
          ph_nxt = '0;
          state_nxt = S_DOUT;
        end
      end
      S_DOUT: begin
        pins_nxt.ce_n = 1'b0;
        pins_nxt.read_strobe_n = (ph_r >= 3'(RD_LOW_CYC));
        ph_nxt = ph_r + 3'd1;
        if (ph_r == 3'(RD_LOW_CYC)) begin
          rd_data_nxt = io_i;
          rd_valid_nxt = 1'b1;
        end
        if (ph_r == 3'(RD_TOTAL_CYC - 1)) begin
          ph_nxt = '0;
          cnt_nxt = cnt_r + 13'd1;
          if (cnt_r == cur_r.len - 13'd1) begin
            state_nxt = S_DONE;
          end
        end
      end
      S_WAKE: begin
        pins_nxt.ce_n = 1'b0;
        tmr_nxt = tmr_r + 1'b1;
        if (tmr_r == TMR_W'(POWERDOWN_WAKE_CYC - 1)) begin
          tmr_nxt = '0;
          state_nxt = S_HOLD;
        end
      end
      S_HOLD: begin
        pins_nxt.ce_n = 1'b1;
        tmr_nxt = tmr_r + 1'b1;
        if (tmr_r == info_r.limit) begin
          state_nxt = S_DONE;
        end
      end
      S_DONE: begin
        pins_nxt.ce_n = 1'b1;
        pins_nxt.wp_n = 1'b0;
        resp_nxt.done = 1'b1;
        resp_nxt.timeout = to_r;
        state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_r <= S_IDLE;
      ph_r <= '0;
      tmr_r <= '0;
      cnt_r <= '0;
      abyte_r <= '0;
      addr_r <= '0;
      cur_r <= '0;
      info_r <= '0;
      second_r <= 1'b0;
      to_r <= 1'b0;
      pins_o <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0};
      resp_o <= '0;
      rd_data_o <= '0;
      rd_valid_o <= 1'b0;
      req_ready_o <= 1'b0;
      npp_row_r <= '0;
      npp_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      ph_r <= ph_nxt;
      tmr_r <= tmr_nxt;
      cnt_r <= cnt_nxt;
      abyte_r <= abyte_nxt;
      addr_r <= addr_nxt;
      cur_r <= cur_nxt;
      info_r <= info_nxt;
      second_r <= second_nxt;
      to_r <= to_nxt;
      pins_o <= pins_nxt;
      resp_o <= resp_nxt;
      rd_data_o <= rd_data_nxt;
      rd_valid_o <= rd_valid_nxt;
      req_ready_o <= ready_nxt;
      npp_row_r <= npp_row_nxt;
      npp_cnt_r <= npp_cnt_nxt;
    end
  end
endmodule

// file: nand_host_pkg.sv
// Constants, commands and carrier types for the NAND bus host controller
package nand_host_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TMR_W = 20;

  // Device busy limits (longest times, rounded down)
  localparam int ARRAY_TO_BUFFER_TIME_US = 25;
  localparam int ARRAY_TO_BUFFER_CYC = ARRAY_TO_BUFFER_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int PAGE_PROGRAM_TIME_US = 700;
  localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int PAGE_PROGRAM_TIME_SCRAMBLED_US = 740;
  localparam int PAGE_PROGRAM_SCRAMBLED_CYC =
    PAGE_PROGRAM_TIME_SCRAMBLED_US * 1000 / CLK_PERIOD_NS;
  localparam int CACHE_PROGRAM_BUSY_US = 700;
  localparam int CACHE_PROGRAM_BUSY_CYC = CACHE_PROGRAM_BUSY_US * 1000 / CLK_PERIOD_NS;
  localparam int CACHE_PROGRAM_BUSY_SCRAMBLED_US = 740;
  localparam int CACHE_PROGRAM_BUSY_SCRAMBLED_CYC =
    CACHE_PROGRAM_BUSY_SCRAMBLED_US * 1000 / CLK_PERIOD_NS;
  localparam int CACHE_READ_BUSY_US = 25;
  localparam int CACHE_READ_BUSY_CYC = CACHE_READ_BUSY_US * 1000 / CLK_PERIOD_NS;
  localparam int DUAL_PLANE_BUSY_US = 1;
  localparam int DUAL_PLANE_BUSY_CYC = DUAL_PLANE_BUSY_US * 1000 / CLK_PERIOD_NS;
  localparam int FEATURE_ACCESS_BUSY_US = 1;
  localparam int FEATURE_ACCESS_BUSY_CYC = FEATURE_ACCESS_BUSY_US * 1000 / CLK_PERIOD_NS;
  localparam int BLOCK_ERASE_TIME_MS = 6;
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DUAL_ERASE_TIME_MS = 7;
  localparam int DUAL_ERASE_CYC = DUAL_ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RESET_TIME_US = 500;
  localparam int RESET_CYC = RESET_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int POWERDOWN_ENTRY_TIME_US = 1;
  localparam int POWERDOWN_ENTRY_CYC = POWERDOWN_ENTRY_TIME_US * 1000 / CLK_PERIOD_NS;

  // Host waits (least times, rounded up)
  localparam int POWERDOWN_EXIT_TIME_US = 35;
  localparam int POWERDOWN_EXIT_CYC =
    (POWERDOWN_EXIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERDOWN_WAKE_PULSE_NS = 20;
  localparam int POWERDOWN_WAKE_CYC =
    (POWERDOWN_WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_TO_WE_NS = 100;
  localparam int WP_TO_WE_CYC = (WP_TO_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_TO_DATA_NS = 70;
  localparam int ADDR_TO_DATA_CYC = (ADDR_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_TO_RE_NS = 80;
  localparam int WE_TO_RE_CYC = (WE_TO_RE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_TO_RE_NS = 20;
  localparam int READY_TO_RE_CYC = (READY_TO_RE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_TO_BUSY_NS = 100;
  localparam int WE_TO_BUSY_CYC = (WE_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Strobe shapes in clock cycles
  localparam int WR_LOW_CYC = 2;
  localparam int WR_TOTAL_CYC = 4;
  localparam int RD_LOW_CYC = 3;
  localparam int RD_TOTAL_CYC = 5;

  localparam int PARTIAL_PROGRAM_LIMIT = 4;
  localparam int PARTIAL_PROGRAM_LIMIT_SCRAMBLED = 1;

  // Command bytes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_CACHE_READ_SEQ = 8'h31;
  localparam logic [7:0] CMD_CACHE_READ_END = 8'h3f;
  localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROGRAM_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_CACHE_PROGRAM = 8'h15;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_PLANE_NEXT = 8'hd1;
  localparam logic [7:0] CMD_SET_FEATURE = 8'hef;
  localparam logic [7:0] CMD_GET_FEATURE = 8'hee;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_POWERDOWN = 8'hb9;

  typedef enum logic [3:0] {
    OP_READ, OP_CACHE_READ_SEQ, OP_CACHE_READ_END, OP_PROGRAM, OP_CACHE_PROGRAM,
    OP_ERASE, OP_ERASE_DUAL, OP_SET_FEATURE, OP_GET_FEATURE, OP_STATUS, OP_RESET,
    OP_POWERDOWN, OP_WAKE
  } op_t;

  typedef enum logic [1:0] {DIR_NONE, DIR_IN, DIR_OUT} dir_t;

  typedef struct packed {
    op_t op;
    logic scrambled;
    logic [39:0] addr;
    logic [23:0] addr2;
    logic [12:0] len;
  } req_t;

  typedef struct packed {
    logic done;
    logic timeout;
    logic refused;
  } resp_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
    logic [7:0] io;
    logic io_oe;
  } pins_t;

  typedef struct packed {
    logic [7:0] cmd1;
    logic [7:0] cmd2;
    logic has_cmd2;
    logic has_addr;
    logic [2:0] first_addr;
    logic [2:0] last_addr;
    dir_t dir;
    logic busy;
    logic write_op;
    logic [TMR_W-1:0] limit;
  } op_info_t;

endpackage

// file: sync3.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module sync3 #(
  parameter logic RST_VAL = 1'b1
)(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic in_i,
  output logic out_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic out_nxt;

  always_comb begin
    out_nxt = out_o;
    if (s2_r == s3_r) begin
      out_nxt = s3_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      out_o <= RST_VAL;
    end else begin
      s1_r <= in_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_o <= out_nxt;
    end
  end
endmodule

// file: tb.sv
// Self-checking bench for the NAND host controller
`timescale 1ns/10ps
module tb import nand_host_pkg::*; ();
  logic core_clk_i = 0, rst_n_i = 0, req_valid_i = 0, wr_valid_i = 0, abort_i = 0, rb_n_i;
  logic req_ready_o, wr_ready_o, rd_valid_o;
  logic [7:0] wr_data_i = 8'h00, rd_data_o, io_i;
  req_t req_i = '0;
  resp_t resp_o, r;
  pins_t pins_o;
  int err_count = 0, tests_run = 0, cyc;
  bit scr = 1'b0;
  logic [7:0] got[$];
  nand_host_ctrl #(.PROG_CYC(2000), .CACHE_PROG_CYC(2000), .ERASE_CYC(2000),
    .ERASE_DUAL_CYC(2000), .RST_CYC(2000))
    dut_u (.*);
  nand_dev_model dev_u (.pins_i(pins_o), .io_o(io_i), .rb_n_o(rb_n_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (rd_valid_o === 1'b1) got.push_back(rd_data_o);
  task automatic chk(string s, logic [23:0] e, logic [23:0] v);
    tests_run++;
    if (e !== v) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic push(int k);
    for (int i = 0; i < k; i++) begin
      wr_data_i = 8'(i);
      wr_valid_i = 1;
      @(negedge core_clk_i);
    end
    wr_valid_i = 0;
  endtask
  task automatic run(op_t op, logic [39:0] a, logic [12:0] n);
    int w;
    w = 0;
    got.delete();
    while (req_ready_o !== 1'b1 && w < 99) begin
      @(negedge core_clk_i);
      w++;
    end
    req_i = '{op, scr, a, 24'h000002, n};
    req_valid_i = 1;
    @(negedge core_clk_i);
    req_valid_i = 0;
    cyc = 0;
    while (resp_o.done !== 1'b1 && cyc < 9999) begin
      @(posedge core_clk_i);
      #1 cyc++;
    end
    r = resp_o;
    chk("done", 1, r.done);
    chk("timeout", 0, r.timeout);
    @(negedge core_clk_i);
  endtask
  task automatic t_read();
    run(OP_READ, 40'h0, 3);
    chk("read data", 24'h000102, {got[0], got[1], got[2]});
    chk("read wait", 1, cyc > 250);
    $display("test read ended");
  endtask
  task automatic t_prog();
    push(17);
    chk("fifo full", 0, wr_ready_o);
    run(OP_PROGRAM, 40'h0000050000, 16);
    chk("prog wait", 1, cyc > 900);
    chk("fifo empty", 1, wr_ready_o);
    for (int i = 0; i < 4; i++) begin
      if (i < 3) push(1);
      run(OP_PROGRAM, 40'h0000050000, 1);
      chk("refused", i == 3, r.refused);
    end
    run(OP_ERASE, 40'h0000050000, 0);
    chk("erase wait", 1, cyc > 900);
    push(1);
    run(OP_PROGRAM, 40'h0000050000, 1);
    chk("refused after erase", 0, r.refused);
    $display("test program ended");
  endtask
  task automatic t_abort();
    push(1);
    abort_i = 1;
    run(OP_PROGRAM, 40'h0000060000, 1);
    abort_i = 0;
    chk("abort cut", 1, cyc < 900);
    $display("test abort ended");
  endtask
  task automatic t_reset();
    run(OP_RESET, 40'h0, 0);
    chk("reset wait", 1, cyc > 200);
    run(OP_STATUS, 40'h0, 1);
    chk("status bytes", 1, got.size());
    $display("test reset ended");
  endtask
  task automatic t_misc();
    run(OP_ERASE_DUAL, 40'h0000070000, 0);
    chk("dual erase wait", 1, cyc > 980);
    run(OP_CACHE_READ_SEQ, 40'h0, 1);
    chk("cache read wait", 1, cyc > 250);
    chk("cache read data", 0, got[0]);
    run(OP_GET_FEATURE, 40'h0, 4);
    chk("feature data", 24'h010203, {got[1], got[2], got[3]});
    scr = 1'b1;
    push(1);
    run(OP_CACHE_PROGRAM, 40'h0000080000, 1);
    chk("cache prog wait", 1, cyc > 900);
    run(OP_CACHE_PROGRAM, 40'h0000080000, 1);
    chk("scrambled refused", 1, r.refused);
    scr = 1'b0;
    run(OP_POWERDOWN, 40'h0, 0);
    chk("powerdown hold", 1, cyc > 100);
    run(OP_WAKE, 40'h0, 0);
    chk("wake wait", 1, cyc > 3500);
    $display("test misc ended");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk_i);
    rst_n_i = 1;
    t_read();
    t_prog();
    t_abort();
    t_reset();
    t_misc();
    conclude();
  end
  initial begin
    #250us;
    err_count++;
    conclude();
  end
endmodule
